// >>> sac_defines.svh
// Constants for the sampling converter control block.
`ifndef SAC_DEFINES_SVH
`define SAC_DEFINES_SVH

// Result width and system clock.
`define SAC_RES_W 14
`define SAC_CLK_PERIOD_NS 10

// Start closer than this to a converter edge lets that edge pass.
`define SAC_START_SETUP_NS 30
`define SAC_START_SETUP_CYC \
    ((`SAC_START_SETUP_NS + `SAC_CLK_PERIOD_NS - 1) / `SAC_CLK_PERIOD_NS)
`define SAC_SINCE_W 4
`define SAC_SINCE_MAX 4'hf

// Counted converter edges within one conversion.
`define SAC_EDGE_W 5
`define SAC_EDGE_LZ0 5'h01
`define SAC_EDGE_DEC_FIRST 5'h02
`define SAC_EDGE_DEC_LAST 5'h0f
`define SAC_EDGE_OUT_FIRST 5'h03
`define SAC_EDGE_OUT_LAST 5'h10
`define SAC_EDGE_FRAME_END 5'h11
`define SAC_EDGE_LATCH 5'h12
`define SAC_EDGE_DONE 5'h13

// Synchroniser lanes and their idle levels.
`define SAC_PIN_W 6
`define SAC_PIN_CCLK 0
`define SAC_PIN_CST 1
`define SAC_PIN_CS 2
`define SAC_PIN_RD 3
`define SAC_PIN_HBE 4
`define SAC_PIN_CMP 5
`define SAC_PIN_RST 6'h0e

// Register map, byte addresses.
`define SAC_ADDR_W 4
`define SAC_OFS_CTRL 4'h0
`define SAC_OFS_STAT 4'h4
`define SAC_OFS_RESULT 4'h8

// Control fields.
`define SAC_CTRL_W 4
`define SAC_CTRL_RST 4'h0
`define SAC_CTRL_WORD 0
`define SAC_CTRL_CONT 1
`define SAC_CTRL_HOST 2
`define SAC_CTRL_SER 3

`endif

// >>> sac_pkg.sv
// Types shared by the sampling converter control block.
`include "sac_defines.svh"
package sac_pkg;
    // Conversion sequencer states, Gray along idle, sync, convert.
    typedef enum logic [1:0] {
        SAC_IDLE = 2'b00,
        SAC_SYNC = 2'b01,
        SAC_CONV = 2'b11
    } sac_state_e;
    // One conversion code.
    typedef logic [`SAC_RES_W-1:0] sac_code_t;
endpackage

// >>> sac_sar_engine.sv
// Successive approximation register that builds one code bit by bit.
`timescale 1ns/1ns
`default_nettype none
`include "sac_defines.svh"
module sac_sar_engine (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Sequencing from the controller.
    input wire logic start,
    input wire logic decide,
    input wire logic cmp_hi,
    // Trial code and the bit decided last.
    output sac_pkg::sac_code_t trial_code,
    output logic last_bit
);
    // Current trial value and the bit under test.
    sac_pkg::sac_code_t trial_r;
    sac_pkg::sac_code_t mask_r;
    logic last_bit_r;
    sac_pkg::sac_code_t kept;
    sac_pkg::sac_code_t mask_nxt;

    // Keep the bit under test when the input lies above the trial.
    always_comb begin
        kept = cmp_hi ? trial_r : (trial_r & ~mask_r);
        mask_nxt = mask_r >> 1;
    end

    // The trial holds the decided bits plus the next test bit; after the lsb, the decided bits alone.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            trial_r <= '0;
            mask_r <= '0;
            last_bit_r <= 1'b0;
        end else if (start) begin
            trial_r <= {1'b1, {(`SAC_RES_W-1){1'b0}}};
            mask_r <= {1'b1, {(`SAC_RES_W-1){1'b0}}};
        end else if (decide) begin
            trial_r <= kept | mask_nxt;
            mask_r <= mask_nxt;
            last_bit_r <= cmp_hi;
        end
    end

    assign trial_code = trial_r;
    assign last_bit = last_bit_r;
endmodule
`default_nettype wire

// >>> sac_top.sv
// Conversion sequencer and output interface of the sampling converter.
//
// Function
// [R1] Conversion takes 19 or 20 converter edges.
// [R2] Start within 30 ns: full 20 edges.
// [R3] Timer mode: hold on start rising edge.
// [R4] Host mode: hold on select falling edge.
// [R5] Timer mode: track again after conversion.
// [R6] Host mode: select plus read start; busy waits.
// [R7] Serial-only variant forces timer-driven starts.
// [R8] Format high: single 14-bit word only.
// [R9] Format low: byte and serial formats available.
// [R10] Top pins become serial pins and byte select.
// [R11] Format and start mode are independent.
// [R12] Word format: msb top line, lsb line zero.
// [R13] Byte select low: low eight result bits.
// [R14] Byte select high: upper six, right-justified.
// [R15] Results are two's complement, span over 16384.
// [R16] Extreme codes follow two's complement order.
// [R17] Host inverts msb for straight binary.
// [R18] Host spaces starts by conversion plus acquisition.
// [R19] Serial frame: two zeros, then 14 bits.
// [R20] Data changes on rising serial clock edge.
// [R21] Serial clock floats after frame or runs.
// [R22] Timer mode: flag high converting, low done.
// [R23] Starts during a conversion are ignored.
// [R24] Result latched before completion is signalled.
//
// Decided for this implementation: register access over Avalon-MM and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "sac_defines.svh"
module sac_top (
    // Clock and synchronous reset.
    input wire logic clk,
    input wire logic nrst,
    // Avalon-MM slave.
    input wire logic [`SAC_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Converter clock and host pins, all asynchronous.
    input wire logic conv_clk,
    input wire logic convert_start_n,
    input wire logic chip_sel_n,
    input wire logic read_n,
    input wire logic upper_byte_select,
    input wire logic cmp_in,
    // Parallel data bus; bit 13 is data_line_top, bit 0 data_line_zero.
    output sac_pkg::sac_code_t data_out,
    output logic data_lo_oe_n,
    output logic data_hi_oe_n,
    // Status and analog front end control.
    output logic busy_int_n,
    output logic track_hold,
    output sac_pkg::sac_code_t dac_code,
    // Open-drain serial lines; low enable pulls the line low.
    output logic sclk_oe_n,
    output logic serial_out_oe_n,
    output logic serial_frame_n_oe_n
);
    // Two-stage synchroniser and one history stage per pin.
    logic [`SAC_PIN_W-1:0] pins;
    logic [`SAC_PIN_W-1:0] sync1_r;
    logic [`SAC_PIN_W-1:0] sync2_r;
    logic [`SAC_PIN_W-1:0] sync3_r;
    // Control register written by software.
    logic [`SAC_CTRL_W-1:0] ctrl_r;
    // Sequencer state and counters.
    sac_pkg::sac_state_e state_r;
    logic [`SAC_SINCE_W-1:0] since_r;
    logic [`SAC_EDGE_W-1:0] edge_r;
    logic [`SAC_EDGE_W-1:0] edge_nxt;
    // Output holding stage and pin registers.
    sac_pkg::sac_code_t result_r;
    sac_pkg::sac_code_t data_out_r;
    logic data_lo_oe_n_r;
    logic data_hi_oe_n_r;
    logic busy_int_n_r;
    logic hold_r;
    logic frame_act_r;
    logic sclk_oe_n_r;
    logic ser_oe_n_r;
    logic frame_oe_n_r;
    // Bus slave registers.
    logic wait_r;
    logic [31:0] rdata_r;
    // Decoded events.
    logic cclk_rise;
    logic cst_rise;
    logic rdsel;
    logic rd_fall;
    logic ser_only;
    logic host_mode;
    logic word_fmt;
    logic start_req;
    logic start;
    logic cnt_edge;
    logic decide;
    logic done;
    logic last_bit;
    sac_pkg::sac_code_t trial_code;

    // Two's complement from the offset binary trial value.
    function automatic sac_pkg::sac_code_t to_twos(
        input sac_pkg::sac_code_t c);
        to_twos = {~c[`SAC_RES_W-1], c[`SAC_RES_W-2:0]};
    endfunction

    // Word placed on the parallel bus for a read.
    function automatic sac_pkg::sac_code_t read_word(
        input sac_pkg::sac_code_t r, input logic word, input logic hbe);
        if (word) begin
            read_word = r;
        end else if (hbe) begin
            read_word = {8'h00, r[13:8]};
        end else begin
            read_word = {6'h00, r[7:0]};
        end
    endfunction

    // Register read decode; unmapped addresses read as zero.
    function automatic logic [31:0] reg_read(
        input logic [`SAC_ADDR_W-1:0] a);
        case (a)
            `SAC_OFS_CTRL: begin
                reg_read = {28'h0000000, ctrl_r};
            end
            `SAC_OFS_STAT: begin
                reg_read = {28'h0000000, frame_act_r, busy_int_n_r,
                    hold_r, state_r != sac_pkg::SAC_IDLE};
            end
            `SAC_OFS_RESULT: begin
                reg_read = {18'h00000, result_r};
            end
            default: begin
                reg_read = 32'h00000000;
            end
        endcase
    endfunction

    assign pins = {cmp_in, upper_byte_select, read_n, chip_sel_n,
        convert_start_n, conv_clk};

    // Every pin passes two flops; the third stage only feeds edge finders.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sync1_r <= `SAC_PIN_RST;
            sync2_r <= `SAC_PIN_RST;
            sync3_r <= `SAC_PIN_RST;
        end else begin
            sync1_r <= pins;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // Edges and modes seen from the clean side of the synchroniser.
    always_comb begin
        cclk_rise = sync2_r[`SAC_PIN_CCLK] & ~sync3_r[`SAC_PIN_CCLK];
        cst_rise = sync2_r[`SAC_PIN_CST] & ~sync3_r[`SAC_PIN_CST];
        rdsel = ~sync2_r[`SAC_PIN_CS] & ~sync2_r[`SAC_PIN_RD];
        rd_fall = rdsel & ~(~sync3_r[`SAC_PIN_CS] & ~sync3_r[`SAC_PIN_RD]);
        // [R7] serial-only variant
        ser_only = ctrl_r[`SAC_CTRL_SER];
        // [R11] independent mode bits
        host_mode = ctrl_r[`SAC_CTRL_HOST] & ~ser_only;
        word_fmt = ctrl_r[`SAC_CTRL_WORD] & ~ser_only;
        // [R3] timer start edge
        // [R4] host select edge
        // [R6] select plus read
        start_req = host_mode ?
            (rd_fall & ~sync2_r[`SAC_PIN_HBE]) : cst_rise;
        // [R23] ignore busy starts
        start = start_req & (state_r == sac_pkg::SAC_IDLE);
        // [R2] late start skips edge
        cnt_edge = cclk_rise & ((state_r == sac_pkg::SAC_CONV) |
            ((state_r == sac_pkg::SAC_SYNC) &
            (since_r >= `SAC_SINCE_W'(`SAC_START_SETUP_CYC))));
        edge_nxt = edge_r + `SAC_EDGE_W'(1);
        decide = cnt_edge & (edge_nxt >= `SAC_EDGE_DEC_FIRST) &
            (edge_nxt <= `SAC_EDGE_DEC_LAST);
        // [R1] fixed counted edges
        done = cnt_edge & (edge_nxt == `SAC_EDGE_DONE);
    end

    // Sequencer: a start waits for the first converter edge, then counts.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_r <= sac_pkg::SAC_IDLE;
        end else begin
            case (state_r)
                sac_pkg::SAC_IDLE: begin
                    if (start) begin
                        state_r <= sac_pkg::SAC_SYNC;
                    end
                end
                sac_pkg::SAC_SYNC: begin
                    // A skipped edge still ends the sync wait.
                    if (cclk_rise) begin
                        state_r <= sac_pkg::SAC_CONV;
                    end
                end
                sac_pkg::SAC_CONV: begin
                    if (done) begin
                        state_r <= sac_pkg::SAC_IDLE;
                    end
                end
                default: begin
                    state_r <= sac_pkg::SAC_IDLE;
                end
            endcase
        end
    end

    // Time since the start, saturating; only read while waiting to sync.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            since_r <= '0;
        end else if (state_r != sac_pkg::SAC_SYNC) begin
            since_r <= '0;
        end else if (since_r != `SAC_SINCE_MAX) begin
            since_r <= since_r + `SAC_SINCE_W'(1);
        end
    end

    // Counted converter edges; a skipped edge leaves the count alone.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            edge_r <= '0;
        end else if (start) begin
            edge_r <= '0;
        end else if (cnt_edge) begin
            edge_r <= edge_nxt;
        end
    end

    // The bit engine decides one bit on each of counted edges 2 to 15, msb first.
    sac_sar_engine u_engine (
        .clk(clk),
        .nrst(nrst),
        .start(start),
        .decide(decide),
        .cmp_hi(sync2_r[`SAC_PIN_CMP]),
        .trial_code(trial_code),
        .last_bit(last_bit)
    );

    // Holding stage loads one edge before completion so reads stay stable.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            result_r <= '0;
        end else if (cnt_edge && edge_nxt == `SAC_EDGE_LATCH) begin
            // [R24] latch before done
            // [R15] two's complement code
            // [R16] extremes keep order
            result_r <= to_twos(trial_code);
        end
    end

    // Track/hold: hold from the start until the conversion ends.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            hold_r <= 1'b0;
        end else if (start) begin
            // [R3] hold on start
            hold_r <= 1'b1;
        end else if (done) begin
            // [R5] back to tracking
            hold_r <= 1'b0;
        end
    end

    // Busy in host mode, interrupt flag in timer mode.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            busy_int_n_r <= 1'b1;
        end else if (start) begin
            // [R6] busy low converting
            busy_int_n_r <= ~host_mode;
        end else if (done) begin
            // [R22] flag low at end
            busy_int_n_r <= host_mode;
        end else if (rd_fall && !host_mode) begin
            // A read clears the flag; an end in the same cycle wins.
            busy_int_n_r <= 1'b1;
        end
    end

    // Serial frame: leading zeros, then bits as soon as they are known.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            frame_act_r <= 1'b0;
            frame_oe_n_r <= 1'b1;
            ser_oe_n_r <= 1'b1;
        end else if (cnt_edge) begin
            // [R20] change on rising edge
            if (edge_nxt == `SAC_EDGE_LZ0) begin
                // [R19] two leading zeros
                frame_act_r <= 1'b1;
                frame_oe_n_r <= word_fmt;
                ser_oe_n_r <= word_fmt;
            end else if (edge_nxt >= `SAC_EDGE_OUT_FIRST &&
                edge_nxt <= `SAC_EDGE_OUT_LAST) begin
                // Msb goes out inverted, as the result; a one releases.
                ser_oe_n_r <= word_fmt |
                    (last_bit ^ (edge_nxt == `SAC_EDGE_OUT_FIRST));
            end else if (edge_nxt == `SAC_EDGE_FRAME_END) begin
                frame_act_r <= 1'b0;
                frame_oe_n_r <= 1'b1;
                ser_oe_n_r <= 1'b1;
            end
        end
    end

    // Serial clock follows the converter clock, three cycles behind the pin.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sclk_oe_n_r <= 1'b1;
        end else begin
            // [R21] float or run on
            // [R9] serial only off word
            sclk_oe_n_r <= ~(~word_fmt & ~sync2_r[`SAC_PIN_CCLK] &
                (ctrl_r[`SAC_CTRL_CONT] | frame_act_r));
        end
    end

    // Parallel bus is driven only while select and read are both low.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            data_out_r <= '0;
            data_lo_oe_n_r <= 1'b1;
            data_hi_oe_n_r <= 1'b1;
        end else begin
            // [R12] word on all lines
            // [R13] low byte select
            // [R14] upper six justified
            data_out_r <= read_word(result_r, word_fmt,
                sync2_r[`SAC_PIN_HBE]);
            // [R8] word format only
            // [R10] top pins given up
            data_lo_oe_n_r <= ~(rdsel & ~ser_only);
            data_hi_oe_n_r <= ~(rdsel & word_fmt);
        end
    end

    // Bus slave: each request is answered with exactly one wait cycle.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wait_r <= 1'b1;
            rdata_r <= 32'h00000000;
        end else if ((avs_read || avs_write) && wait_r) begin
            wait_r <= 1'b0;
            rdata_r <= avs_read ? reg_read(avs_address) : 32'h00000000;
        end else begin
            wait_r <= 1'b1;
        end
    end

    // Control register takes a write at the edge that samples waitrequest low.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctrl_r <= `SAC_CTRL_RST;
        end else if (avs_write && !wait_r &&
            avs_address == `SAC_OFS_CTRL) begin
            ctrl_r <= avs_writedata[`SAC_CTRL_W-1:0];
        end
    end

    assign avs_readdata = rdata_r;
    assign avs_waitrequest = wait_r;
    assign data_out = data_out_r;
    assign data_lo_oe_n = data_lo_oe_n_r;
    assign data_hi_oe_n = data_hi_oe_n_r;
    assign busy_int_n = busy_int_n_r;
    assign track_hold = hold_r;
    assign dac_code = trial_code;
    assign sclk_oe_n = sclk_oe_n_r;
    assign serial_out_oe_n = ser_oe_n_r;
    assign serial_frame_n_oe_n = frame_oe_n_r;
endmodule
`default_nettype wire

// >>> sac_top_sva.sv
// Concurrent checks on the ports of the converter control block.
`timescale 1ns/1ns
`default_nettype none
module sac_top_sva (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Bus handshake.
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    // Host pins.
    input wire logic chip_sel_n,
    input wire logic read_n,
    input wire logic upper_byte_select,
    // Outputs under watch.
    input wire sac_pkg::sac_code_t data_out,
    input wire logic data_lo_oe_n,
    input wire logic data_hi_oe_n,
    input wire logic track_hold,
    input wire logic sclk_oe_n,
    input wire logic serial_out_oe_n,
    input wire logic serial_frame_n_oe_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Cycles the strobe has been low; it saturates so it never wraps.
    logic [7:0] flen_r;
    always_ff @(posedge clk) begin
        if (!nrst || serial_frame_n_oe_n) begin
            flen_r <= 8'h00;
        end else if (flen_r != 8'hff) begin
            flen_r <= flen_r + 8'h01;
        end
    end
    // A frame opens with two zero bits.
    sequence s_frame_open;
        $fell(serial_frame_n_oe_n);
    endsequence
    sequence s_lead_zero;
        (!serial_out_oe_n) [*8];
    endsequence
    chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("bus answer late");
    chk_wait_idle: assert property (!(avs_read || avs_write)
        |=> avs_waitrequest) else $error("answer without request");
    chk_hi_sel: assert property (!data_hi_oe_n
        |-> $past(!chip_sel_n && !read_n, 3)) else $error("upper lines driven");
    chk_lo_sel: assert property (!data_lo_oe_n
        |-> $past(!chip_sel_n && !read_n, 3)) else $error("lower lines driven");
    chk_byte_zero: assert property (!data_lo_oe_n && data_hi_oe_n
        && $past(upper_byte_select, 3) |-> data_out[7:6] == 2'b00)
        else $error("byte not justified");
    chk_hold_frame: assert property (!serial_frame_n_oe_n
        |-> track_hold) else $error("frame outside hold");
    chk_frame_len: assert property ($rose(serial_frame_n_oe_n)
        |-> flen_r >= 8'hc5 && flen_r <= 8'hcb) else $error("frame length");
    chk_lead_zero: assert property (s_frame_open |-> s_lead_zero)
        else $error("lead bits not zero");
    chk_data_edge: assert property (!serial_frame_n_oe_n
        && $past(!serial_frame_n_oe_n) && $changed(serial_out_oe_n)
        |-> $rose(sclk_oe_n)) else $error("data off rising clock");
    chk_frame_done: assert property ($fell(track_hold)
        |-> serial_frame_n_oe_n && $past(serial_frame_n_oe_n, 20))
        else $error("done inside frame");
endmodule
`default_nettype wire

// >>> sac_far_model.sv
// Converter clock source, comparator and pull-ups at the far side.
`timescale 1ns/1ns
`default_nettype none
module sac_far_model (
    // Analog level as the code it should convert to.
    input wire sac_pkg::sac_code_t level,
    // Trial code and open-drain enables from the block.
    input wire sac_pkg::sac_code_t dac_code,
    input wire logic sclk_oe_n,
    input wire logic serial_out_oe_n,
    input wire logic serial_frame_n_oe_n,
    // Converter clock and comparator answer.
    output logic conv_clk,
    output logic cmp_in,
    // Resolved line levels.
    output logic sclk_w,
    output logic serial_out_w,
    output logic frame_w
);
    // Free-running 125 ns clock, split 62/63 in 1 ns steps.
    initial begin
        conv_clk = 1'b0;
        #3;
        forever begin
            conv_clk = 1'b1;
            #62;
            conv_clk = 1'b0;
            #63;
        end
    end
    // two's complement level
    // Trials are offset binary, so the level's sign bit is flipped first.
    assign cmp_in = {~level[13], level[12:0]} >= dac_code;
    // Released lines float up to the pull-up level.
    assign sclk_w = sclk_oe_n;
    assign serial_out_w = serial_out_oe_n;
    assign frame_w = serial_frame_n_oe_n;
endmodule
`default_nettype wire

// >>> tb_sac_top.sv
// Self-checking bench for the converter control block.
`timescale 1ns/1ns
`default_nettype none
`include "sac_defines.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_sac_top;
    // Clock, reset and bus.
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0, avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    // Host pins; the strobes idle high, byte select low.
    logic convert_start_n = 1'b1, chip_sel_n = 1'b1, read_n = 1'b1;
    logic upper_byte_select = 1'b0;
    // Block outputs and far side lines.
    sac_pkg::sac_code_t data_out, dac_code, level = 14'h0000;
    logic data_lo_oe_n, data_hi_oe_n, busy_int_n, track_hold;
    logic sclk_oe_n, serial_out_oe_n, serial_frame_n_oe_n;
    logic conv_clk, cmp_in, sclk_w, serial_out_w, frame_w;
    // Counters, capture and random state.
    int fail_count = 0, tests_run = 0;
    int edges, frames, nb, sck;
    logic [15:0] sh, word;
    logic [31:0] seed = 32'h0000_0049;
    sac_pkg::sac_code_t codes [4] = '{14'h1fff, 14'h2000, 14'h1ffe, 14'h2001};
    logic [3:0] cfg [7] = '{4'h1, 4'h0, 4'h2, 4'h8, 4'hc, 4'h5, 4'h4};
    sac_top i_sac_top (.*);
    sac_far_model i_sac_far_model (.*);
    always #5 clk = ~clk;
    // Raw converter edges and serial clock toggles.
    always @(posedge conv_clk) edges++;
    always @(sclk_w) sck++;
    // Bits are taken on falling clock edges while the strobe is low.
    always @(negedge frame_w) begin
        sh = 16'h0000;
        nb = 0;
    end
    always @(negedge sclk_w) if (frame_w === 1'b0) begin
        sh = {sh[14:0], serial_out_w};
        nb++;
    end
    always @(posedge frame_w) begin
        word = sh;
        frames++;
    end
    // Xorshift source; the fixed start value keeps runs repeatable.
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Expected byte: low eight bits, or upper six with two zeros above.
    function logic [7:0] byte_exp(input sac_pkg::sac_code_t c, input logic h);
        return h ? {2'b00, c[13:8]} : c[7:0];
    endfunction
    task summarize();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // One bus cycle, held until waitrequest is sampled low.
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            fail_count++;
            summarize();
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // Bounded wait for a level on a block output.
    task automatic wait_lvl(ref logic s, input logic v);
        int n = 0;
        while (s !== v && n < 400) begin
            @(posedge clk);
            n++;
        end
        if (n >= 400) begin
            fail_count++;
            summarize();
        end
    endtask
    // One parallel read with the given byte select.
    task pread(input logic hb, output sac_pkg::sac_code_t q, output logic lo,
        output logic hi);
        @(posedge clk);
        chip_sel_n <= 1'b0;
        read_n <= 1'b0;
        upper_byte_select <= hb;
        repeat (5) @(posedge clk);
        #1 q = data_out;
        lo = data_lo_oe_n;
        hi = data_hi_oe_n;
        @(posedge clk);
        chip_sel_n <= 1'b1;
        read_n <= 1'b1;
        repeat (5) @(posedge clk);
    endtask
    // Convert code c; m places the start against the clock.
    task convert(input logic [3:0] ctrl, input sac_pkg::sac_code_t c,
        input int m);
        logic [31:0] q;
        sac_pkg::sac_code_t d;
        logic lo, hi, host;
        int f0, n;
        host = ctrl[2] && !ctrl[3];
        f0 = frames;
        level = c;
        if (host) begin
            // start line low, select with read starts
            @(posedge clk);
            convert_start_n <= 1'b0;
            repeat (3) @(posedge clk);
            chip_sel_n <= 1'b0;
            read_n <= 1'b0;
            upper_byte_select <= 1'b0;
            edges = 0;
            repeat (5) @(posedge clk);
            #1 `CHK(busy_int_n, 1'b0)
            `CHK(track_hold, 1'b1)
            wait_lvl(busy_int_n, 1'b1);
            `CHK(edges == 19 || edges == 20, 1'b1)
            repeat (4) @(posedge clk);
            #1 d = data_out;
            if (ctrl[0]) `CHK(d, c)
            else `CHK(d[7:0], byte_exp(c, 1'b0))
            @(posedge clk);
            chip_sel_n <= 1'b1;
            read_n <= 1'b1;
        end else begin
            @(posedge conv_clk);
            repeat (m - 3) @(posedge clk);
            convert_start_n <= 1'b0;
            repeat (3) @(posedge clk);
            convert_start_n <= 1'b1;
            edges = 0;
            repeat (5) @(posedge clk);
            #1 `CHK(track_hold, 1'b1)
            `CHK(busy_int_n, 1'b1)
            // A start in mid-conversion changes nothing.
            if (m == 8) begin
                repeat (60) @(posedge clk);
                convert_start_n <= 1'b0;
                repeat (3) @(posedge clk);
                convert_start_n <= 1'b1;
            end
            wait_lvl(busy_int_n, 1'b0);
            `CHK(edges, (m == 12) ? 20 : 19)
        end
        #1 `CHK(track_hold, 1'b0)
        bus(1'b0, `SAC_OFS_RESULT, 32'h0, q);
        `CHK(q[13:0], c)
        `CHK(dac_code, {~c[13], c[12:0]})
        if (!ctrl[0]) begin
            `CHK(frames - f0, 1)
            `CHK(nb, 16)
            `CHK(word, {2'b00, c})
            n = sck;
            repeat (40) @(posedge clk);
            `CHK(sck != n, ctrl[1])
        end else `CHK(frames - f0, 0)
        if (ctrl[3]) begin
            pread(1'b1, d, lo, hi);
            `CHK(lo, 1'b1)
            `CHK(track_hold, 1'b0)
        end else begin
            if (!host) begin
                pread(1'b0, d, lo, hi);
                if (ctrl[0]) `CHK(d, c)
                else `CHK(d[7:0], byte_exp(c, 1'b0))
                `CHK(hi, ctrl[0] ? 1'b0 : 1'b1)
                `CHK(busy_int_n, 1'b1)
            end
            if (!ctrl[0]) begin
                pread(1'b1, d, lo, hi);
                `CHK(d[7:0], byte_exp(c, 1'b1))
            end
        end
        repeat (200) @(posedge clk);
    endtask
    // Registers first, then every format and start mode.
    initial begin
        logic [31:0] q, r;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        frames = 0;
        bus(1'b0, `SAC_OFS_CTRL, 32'h0, q);
        `CHK(q, 32'h0000_0000)
        bus(1'b1, `SAC_OFS_CTRL, 32'hffff_fff5, q);
        bus(1'b1, 4'hc, 32'hffff_ffff, q);
        bus(1'b0, `SAC_OFS_CTRL, 32'h0, q);
        `CHK(q, 32'h0000_0005)
        bus(1'b0, 4'hc, 32'h0, q);
        `CHK(q, 32'h0000_0000)
        for (int i = 0; i < 7; i++) begin
            for (int j = 0; j < 3; j++) begin
                r = xs();
                bus(1'b1, `SAC_OFS_CTRL, {28'h0, cfg[i]}, q);
                // word and byte formats under both start modes, serial-only under timer starts
                convert(cfg[i], (j == 0) ? codes[i % 4] : r[13:0],
                    (j == 0) ? 12 : ((j == 1) ? 4 : 8));
            end
        end
        summarize();
    end
endmodule
bind sac_top sac_top_sva i_sac_top_sva (.*);
`default_nettype wire
